/* burner_startup_sequencer.sv */
// Purpose: power-on initiate, standby and pre-purge of a burner sequencer
// Assumes: field inputs asynchronous, one 50 MHz clock, resetn = power-on
// Notes: ignition and later states are outside; trialStart hands over
//
// How it works
// - Reset (power applied) puts the sequencer in initiate.
// - A bad line in standby, purge, low fire or ignition sends the sequencer back to initiate.
// - Initiate lasts ten seconds while the line stays good.
// - Line fault in initiate holds, showing hold for at least five seconds.
// - After a hold the initiate timer restarts from zero.
// - Hold lasting four minutes uncorrected leads to lockout.
// - Dropout, noise or brownout all clear lineOk and raise a hold.
// - Blower output stays off through initiate whatever inputs do.
// - Standby starts on demand, proving demand when valve proving is needed.
// - Leaving standby needs burner switch, limits, control, monitors correct.
// - Purge time is selectable between 30 and 150 seconds.
// - All listed interlocks and switches are checked before purge proceeds.
// - Purge start energizes blower and drives firing rate to high fire.
// - Purge timing counts only with lockout string and high fire closed.
// - Valve tests run alongside purge from ten seconds in, when scheduled.
// - Pre-ignition interlock opening in purge trips, except during tests.
// - Lockout interlocks not closed ten seconds after demand trip.
// - Purge expiry drives firing rate toward low fire.
// - Ignition trial begins only once the low fire switch is made.
// - Purge duration comes from the fitted purge card setting, or from the purge register when useCard is clear.
`timescale 1ns/1ps
module burner_startup_sequencer
    import burner_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYC,
    parameter int HOLD_SHOW_CYCLES = HOLD_SHOW_CYC,
    parameter longint HOLD_LOCK_CYCLES = HOLD_LOCK_CYC,
    parameter int AIRFLOW_CYCLES = AIRFLOW_CYC,
    parameter int PROVE_START_CYCLES = PROVE_START_CYC,
    parameter int SEC_CYCLES = SEC_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Field pins, asynchronous
    input wire field_in_s fieldIn,
    input wire logic [7:0] purgeCard,
    // Field outputs
    output field_out_s fieldOut,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    field_in_s syncA, syncB;
    logic [7:0] cardA, cardB;

    // Two stages; only syncB and cardB are looked at by logic
    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncA <= FIELD_IDLE;
            syncB <= FIELD_IDLE;
            cardA <= '0;
            cardB <= '0;
        end else begin
            syncA <= fieldIn;
            syncB <= syncA;
            cardA <= purgeCard;
            cardB <= cardA;
        end
    end

    // ------------------------------------------------------------
    // Register bus state
    // ------------------------------------------------------------
    logic awHeld, wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [2:0] vpSchedule;
    logic useCard;
    logic [7:0] purgeSec;
    logic resetReq;
    logic next_awHeld, next_wHeld, next_bvalid, next_arready, next_rvalid;
    logic [7:0] next_awAddr;
    logic [31:0] next_wData, next_rdata;
    logic [3:0] next_wStrb;
    logic [1:0] next_bresp, next_rresp;
    logic [2:0] next_vpSchedule;
    logic next_useCard, next_resetReq;
    logic [7:0] next_purgeSec;
    logic doWrite;

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    seq_e state, next_state;
    logic [31:0] timer, next_timer;
    logic [35:0] holdTimer, next_holdTimer;
    logic [31:0] demandTimer, next_demandTimer;
    logic [35:0] purgeTimer, next_purgeTimer;
    logic [7:0] tripCode, next_tripCode;
    field_out_s next_out;

    // Derived conditions
    logic proveNeeded, activeDemand, standbyOk, purgeOk, proveSched;
    logic [7:0] effPurge, clampPurge;
    logic [35:0] purgeCycles;

    // Valve proving on the purge side for Before, Split or Both
    // demand selection
    assign proveSched = (vpSchedule == VP_BEFORE) ||
                        (vpSchedule == VP_SPLIT) || (vpSchedule == VP_BOTH);
    assign proveNeeded = (vpSchedule != VP_NEVER);
    assign activeDemand = proveNeeded ? syncB.provingDemand : syncB.demand;
    assign standbyOk = activeDemand && syncB.burnerSwitch &&
                       syncB.limitsOk && syncB.monitorOk;
    assign purgeOk = standbyOk && syncB.runningIlk && syncB.runTest;
    assign effPurge = useCard ? cardB : purgeSec;
    assign clampPurge = (effPurge < 8'(PURGE_MIN_SEC)) ? 8'(PURGE_MIN_SEC) :
                        (effPurge > 8'(PURGE_MAX_SEC)) ? 8'(PURGE_MAX_SEC) :
                        effPurge;
    assign purgeCycles = 36'(clampPurge) * 36'(SEC_CYCLES);

    // Sequencer next-state logic
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_holdTimer = holdTimer;
        next_demandTimer = demandTimer;
        next_purgeTimer = purgeTimer;
        next_tripCode = tripCode;
        next_out = fieldOut;
        next_out.trialStart = 1'b0;
        next_out.holdShown = (state == ST_HOLD);
        case (state)
            ST_INITIATE: begin
                next_out = '0;
                next_timer = timer + 32'h1;
                if (!syncB.lineOk) begin
                    next_state = ST_HOLD;
                    next_timer = '0;
                    next_holdTimer = '0;
                end else if (timer >= 32'(INIT_CYCLES - 1)) begin
                    next_state = ST_STANDBY;
                    next_timer = '0;
                end
            end
            ST_HOLD: begin
                next_out = '0;
                next_out.holdShown = 1'b1;
                next_timer = timer + 32'h1;
                if (!syncB.lineOk) begin
                    next_holdTimer = holdTimer + 36'h1;
                end else begin
                    next_holdTimer = '0;
                end
                if (holdTimer >= 36'(HOLD_LOCK_CYCLES - 1)) begin
                    next_state = ST_LOCKOUT;
                    next_tripCode = 8'h01;
                end else if (syncB.lineOk &&
                             timer >= 32'(HOLD_SHOW_CYCLES - 1)) begin
                    next_state = ST_INITIATE;
                    next_timer = '0;
                end
            end
            ST_STANDBY: begin
                next_out = '0;
                next_demandTimer = '0;
                next_purgeTimer = '0;
                if (standbyOk && syncB.preIgnIlk) begin
                    next_state = ST_PURGE;
                    next_out.blower = 1'b1;
                    next_out.rateHigh = 1'b1;
                end
            end
            ST_PURGE: begin
                next_out.blower = 1'b1;
                next_out.rateHigh = 1'b1;
                next_out.rateLow = 1'b0;
                if (!syncB.lockoutIlk) begin
                    next_demandTimer = demandTimer + 32'h1;
                end
                if (syncB.lockoutIlk && syncB.highFireSw) begin
                    next_purgeTimer = purgeTimer + 36'h1;
                end
                next_out.provingActive = proveSched &&
                    syncB.provingDemand &&
                    (purgeTimer >= 36'(PROVE_START_CYCLES));
                if (!activeDemand) begin
                    next_state = ST_STANDBY;
                    next_out = '0;
                end else if (!purgeOk) begin
                    next_state = ST_LOCKOUT;
                    next_tripCode = 8'h02;
                end else if (!syncB.preIgnIlk && !fieldOut.provingActive) begin
                    next_state = ST_LOCKOUT;
                    next_tripCode = 8'h03;
                end else if (!syncB.lockoutIlk &&
                             demandTimer >= 32'(AIRFLOW_CYCLES - 1)) begin
                    next_state = ST_LOCKOUT;
                    next_tripCode = 8'h04;
                end else if (purgeTimer >= purgeCycles - 36'h1) begin
                    next_state = ST_LOWFIRE;
                    next_out.rateHigh = 1'b0;
                    next_out.rateLow = 1'b1;
                    next_out.provingActive = 1'b0;
                end
            end
            ST_LOWFIRE: begin
                next_out.rateHigh = 1'b0;
                next_out.rateLow = 1'b1;
                if (!purgeOk || !syncB.lockoutIlk) begin
                    next_state = ST_LOCKOUT;
                    next_tripCode = 8'h05;
                end else if (syncB.lowFireSw) begin
                    next_state = ST_IGNITION;
                    next_out.trialStart = 1'b1;
                    next_out.fuelEnable = 1'b1;
                end
            end
            ST_IGNITION: begin
                // Held here; downstream logic owns the trial
                next_out.fuelEnable = 1'b1;
                if (!activeDemand) begin
                    next_state = ST_STANDBY;
                    next_out = '0;
                end
            end
            ST_LOCKOUT: begin
                next_out = '0;
                next_out.alarm = 1'b1;
                if (resetReq) begin
                    next_state = ST_INITIATE;
                    next_timer = '0;
                    next_tripCode = '0;
                end
            end
            default: begin
                next_state = ST_LOCKOUT;
                next_out = '0;
            end
        endcase
        if (!syncB.lineOk && state != ST_INITIATE && state != ST_HOLD &&
            state != ST_LOCKOUT) begin
            next_state = ST_INITIATE;
            next_timer = '0;
            next_out = '0;
        end
    end

    // Sequencer registers; reset enters initiate
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ST_INITIATE;
            timer <= '0;
            holdTimer <= '0;
            demandTimer <= '0;
            purgeTimer <= '0;
            tripCode <= '0;
            fieldOut <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            holdTimer <= next_holdTimer;
            demandTimer <= next_demandTimer;
            purgeTimer <= next_purgeTimer;
            tripCode <= next_tripCode;
            fieldOut <= next_out;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Write fires when both halves are held and no response pends
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;

    // Bus next-state logic
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_vpSchedule = vpSchedule;
        next_useCard = useCard;
        next_purgeSec = purgeSec;
        next_resetReq = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_awHeld = 1'b1;
            next_awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_wHeld = 1'b1;
            next_wData = s_axi_wdata;
            next_wStrb = s_axi_wstrb;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            case (awAddr)
                CTRL_OFS: begin
                    if (wStrb[0]) begin
                        next_vpSchedule = wData[2:0];
                        next_useCard = wData[3];
                        next_resetReq = wData[4];
                    end
                end
                PURGE_OFS: begin
                    if (wStrb[0]) begin
                        next_purgeSec = wData[7:0];
                    end
                end
                STATUS_OFS, INPUT_OFS: begin
                    next_bresp = RESP_OKAY;
                end
                default: begin
                    next_bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            next_arready = 1'b1;
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS: next_rdata = {27'h0, 1'b0, useCard, vpSchedule};
                STATUS_OFS: next_rdata = {8'h0, tripCode, fieldOut, 5'h0,
                                          state};
                PURGE_OFS: next_rdata = {16'h0, clampPurge, purgeSec};
                INPUT_OFS: next_rdata = {20'h0, syncB};
                default: begin
                    next_rdata = '0;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            wStrb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            vpSchedule <= VP_NEVER;
            useCard <= 1'b1;
            purgeSec <= PURGE_RST;
            resetReq <= 1'b0;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            // Ready only while the holding slot is empty
            s_axi_awready <= !next_awHeld && !s_axi_awready;
            s_axi_wready <= !next_wHeld && !s_axi_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            vpSchedule <= next_vpSchedule;
            useCard <= next_useCard;
            purgeSec <= next_purgeSec;
            resetReq <= next_resetReq;
        end
    end

endmodule : burner_startup_sequencer

/* burner_pkg.sv */
// Purpose: shared constants and carriers for the burner start-up sequencer
// Assumes: 50 MHz clock, AXI4-Lite register access
// Notes: times are kept in their own unit, cycle counts derived from them
package burner_pkg;

    // ------------------------------------------------------------
    // Clock and times
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50000000;
    localparam int INIT_SEC = 10;
    localparam int HOLD_SHOW_SEC = 5;
    localparam int HOLD_LOCK_SEC = 240;
    localparam int AIRFLOW_SEC = 10;
    localparam int PROVE_START_SEC = 10;
    localparam int PURGE_MIN_SEC = 30;
    localparam int PURGE_MAX_SEC = 150;
    localparam int INIT_CYC = INIT_SEC * CLK_HZ;
    localparam int HOLD_SHOW_CYC = HOLD_SHOW_SEC * CLK_HZ;
    localparam longint HOLD_LOCK_CYC = longint'(HOLD_LOCK_SEC) * CLK_HZ;
    localparam int AIRFLOW_CYC = AIRFLOW_SEC * CLK_HZ;
    localparam int PROVE_START_CYC = PROVE_START_SEC * CLK_HZ;
    localparam int SEC_CYC = CLK_HZ;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PURGE_OFS = 8'h08;
    localparam logic [7:0] INPUT_OFS = 8'h0C;
    localparam logic [7:0] PURGE_RST = 8'h1E;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Valve proving schedule codes
    localparam logic [2:0] VP_NEVER = 3'h0;
    localparam logic [2:0] VP_BEFORE = 3'h1;
    localparam logic [2:0] VP_AFTER = 3'h2;
    localparam logic [2:0] VP_SPLIT = 3'h3;
    localparam logic [2:0] VP_BOTH = 3'h4;

    typedef enum logic [2:0] {
        ST_INITIATE = 3'b000,
        ST_HOLD = 3'b001,
        ST_STANDBY = 3'b010,
        ST_PURGE = 3'b011,
        ST_LOWFIRE = 3'b100,
        ST_IGNITION = 3'b101,
        ST_LOCKOUT = 3'b110
    } seq_e;

    // Field inputs after synchronising
    typedef struct packed {
        logic lineOk;
        logic demand;
        logic provingDemand;
        logic burnerSwitch;
        logic limitsOk;
        logic runningIlk;
        logic preIgnIlk;
        logic runTest;
        logic lockoutIlk;
        logic highFireSw;
        logic lowFireSw;
        logic monitorOk;
    } field_in_s;
    // Synchroniser reset: good line, so no false hold
    localparam field_in_s FIELD_IDLE = '{lineOk: 1'b1, default: 1'b0};

    // Field outputs
    typedef struct packed {
        logic blower;
        logic rateHigh;
        logic rateLow;
        logic provingActive;
        logic fuelEnable;
        logic holdShown;
        logic alarm;
        logic trialStart;
    } field_out_s;

endpackage : burner_pkg

/* burner_props.sv */
// Purpose: timing checks on the sequencer field pins
// Assumes: shortened counts handed on by the bind
// Notes: raw pins lead the synced view by two cycles, margins allow it
`timescale 1ns/1ps
module burner_props
    import burner_pkg::*;
#(
    parameter int HOLD_SHOW_CYCLES = 50,
    parameter int PURGE_CYC = 300
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Field pins
    input wire field_in_s fieldIn,
    input wire field_out_s fieldOut
);
    int holdCnt;
    int next_holdCnt;
    int purgeCnt;
    int next_purgeCnt;
    // Hold length and purge cycles seen with both switches made
    always_comb begin
        next_holdCnt = fieldOut.holdShown ? holdCnt + 1 : 0;
        next_purgeCnt = fieldOut.blower ? purgeCnt : 0;
        if (fieldOut.rateHigh && fieldIn.lockoutIlk && fieldIn.highFireSw)
            next_purgeCnt = purgeCnt + 1;
    end
    always_ff @(posedge clk) begin
        holdCnt <= resetn ? next_holdCnt : 0;
        purgeCnt <= resetn ? next_purgeCnt : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_init_quiet: assert property (
        $rose(resetn) |-> !fieldOut.blower [*8])
        else $error("blower on right after power-on");
    chk_line_drop: assert property (
        !fieldIn.lineOk [*6] |-> !fieldOut.blower && !fieldOut.fuelEnable)
        else $error("outputs live on a bad line");
    chk_hold_shown: assert property (
        $fell(fieldOut.holdShown) |-> holdCnt >= HOLD_SHOW_CYCLES)
        else $error("hold shown too briefly");
    chk_purge_start: assert property (
        $rose(fieldOut.blower) |-> fieldOut.rateHigh)
        else $error("blower without high fire command");
    chk_purge_len: assert property (
        $rose(fieldOut.rateLow) && fieldOut.blower
        |-> purgeCnt >= PURGE_CYC - 4)
        else $error("purge ended early");
    chk_low_fire: assert property (
        fieldOut.trialStart |-> $past(fieldIn.lowFireSw, 3))
        else $error("trial without low fire switch");
    chk_preign_trip: assert property (
        (fieldOut.rateHigh && !fieldOut.provingActive
        && !fieldIn.preIgnIlk) [*3] |-> ##[1:6] fieldOut.alarm)
        else $error("no trip on open pre-ignition interlock");
    chk_lock_fuel: assert property (
        fieldOut.alarm |-> !fieldOut.fuelEnable && !fieldOut.trialStart)
        else $error("fuel live in lockout");
endmodule : burner_props

/* field_model.sv */
// Purpose: burner field side with a travelling firing-rate motor
// Assumes: bench sets the wanted switch levels
// Notes: end switches close only when the motor reaches its end
`timescale 1ns/1ps
module field_model
    import burner_pkg::*;
#(
    parameter int MOVE = 6
) (
    // Clock and commands
    input wire logic clk,
    input wire field_in_s want,
    input wire field_out_s fieldOut,
    // Pins seen by the sequencer
    output field_in_s fieldIn
);
    int pos = 0;
    int next_pos;
    // Motor steps once a cycle toward its command
    always_comb begin
        next_pos = pos;
        if (fieldOut.rateHigh && pos < MOVE)
            next_pos = pos + 1;
        else if (fieldOut.rateLow && pos > 0)
            next_pos = pos - 1;
    end
    always_ff @(posedge clk) begin
        pos <= next_pos;
    end
    // Switch made only at the end of travel, so no early proof
    always_comb begin
        fieldIn = want;
        fieldIn.highFireSw = want.highFireSw && pos == MOVE;
        fieldIn.lowFireSw = want.lowFireSw && pos == 0;
    end
endmodule : field_model

/* testbench.sv */
// Purpose: directed scenarios for the burner start-up sequencer
// Assumes: shortened counts, purge card at 30 seconds
// Notes: status is read back over AXI4-Lite
`timescale 1ns/1ps
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin \
    miscompares++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module testbench;
    import burner_pkg::*;
    logic clk = 0;
    logic resetn = 0;
    field_in_s want, fieldIn;
    field_out_s fieldOut;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [7:0] card = 8'h1E;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] d;
    logic [1:0] r;
    int miscompares = 0, totalChecks = 0;
    // One shortened second is SEC cycles
    localparam int SEC = 10;
    burner_startup_sequencer #(.INIT_CYCLES(10 * SEC),
        .HOLD_SHOW_CYCLES(5 * SEC), .HOLD_LOCK_CYCLES(40 * SEC),
        .AIRFLOW_CYCLES(10 * SEC), .PROVE_START_CYCLES(5 * SEC),
        .SEC_CYCLES(SEC)) DUT (
        .clk(clk), .resetn(resetn), .fieldIn(fieldIn), .purgeCard(card),
        .fieldOut(fieldOut), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    field_model u_field (.clk(clk), .want(want), .fieldOut(fieldOut),
        .fieldIn(fieldIn));
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Write: both channels offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask : axr
    task automatic st(input logic [2:0] e);
        axr(STATUS_OFS);
        `CHK("state", e, d[2:0])
    endtask : st
    task automatic t_power();
        st(3'h0);
        axr(CTRL_OFS);
        `CHK("useCard", 1'b1, d[3])
        tick(70);
        st(3'h0);
        `CHK("blower", 1'b0, fieldOut.blower)
        tick(40);
        st(3'h2);
    endtask : t_power
    // Hold, restart of initiate, then hold timeout and lockout reset
    task automatic t_hold();
        want.lineOk <= 1'b0;
        tick(6);
        st(3'h1);
        `CHK("hold", 1'b1, fieldOut.holdShown)
        want.lineOk <= 1'b1;
        tick(30);
        st(3'h1);
        tick(20);
        st(3'h0);
        tick(70);
        st(3'h0);
        tick(40);
        st(3'h2);
        want.lineOk <= 1'b0;
        tick(420);
        st(3'h6);
        `CHK("alarm", 1'b1, fieldOut.alarm)
        want.lineOk <= 1'b1;
        tick(20);
        st(3'h6);
        axw(CTRL_OFS, 32'h18);
        tick(5);
        axr(STATUS_OFS);
        `CHK("unlocked", 3'h0, d[2:0])
        tick(130);
    endtask : t_hold
    task automatic t_purge();
        want.lowFireSw <= 1'b0;
        want.demand <= 1'b1;
        tick(8);
        st(3'h3);
        `CHK("blower", 1'b1, fieldOut.blower)
        `CHK("high", 1'b1, fieldOut.rateHigh)
        tick(250);
        st(3'h3);
        tick(80);
        `CHK("low", 1'b1, fieldOut.rateLow)
        st(3'h4);
        want.lowFireSw <= 1'b1;
        for (int n = 0; n < 20 && fieldOut.trialStart !== 1'b1; n++)
            tick(1);
        `CHK("trial", 1'b1, fieldOut.trialStart)
        st(3'h5);
        want.demand <= 1'b0;
        tick(8);
        st(3'h2);
    endtask : t_purge
    // Valve tests beside purge for each schedule that asks for them
    task automatic t_prove();
        logic [2:0] codes[3];
        codes = '{VP_BEFORE, VP_SPLIT, VP_BOTH};
        foreach (codes[i]) begin
            axw(CTRL_OFS, {29'h1, codes[i]});
            want.demand <= 1'b1;
            tick(10);
            st(3'h2);
            want.provingDemand <= 1'b1;
            tick(40);
            `CHK("prove", 1'b0, fieldOut.provingActive)
            tick(30);
            `CHK("prove", 1'b1, fieldOut.provingActive)
            want.preIgnIlk <= 1'b0;
            tick(10);
            st(3'h3);
            want.preIgnIlk <= 1'b1;
            want.demand <= 1'b0;
            want.provingDemand <= 1'b0;
            tick(8);
            st(3'h2);
        end
    endtask : t_prove
    task automatic t_trip();
        axw(CTRL_OFS, 32'h08);
        want.highFireSw <= 1'b0;
        want.demand <= 1'b1;
        tick(400);
        st(3'h3);
        want.highFireSw <= 1'b1;
        want.preIgnIlk <= 1'b0;
        tick(8);
        st(3'h6);
        `CHK("fuel", 1'b0, fieldOut.fuelEnable)
        want.preIgnIlk <= 1'b1;
        axw(CTRL_OFS, 32'h18);
        tick(130);
        want.lockoutIlk <= 1'b0;
        tick(120);
        axr(STATUS_OFS);
        `CHK("trip", 8'h04, d[23:16])
        axr(8'h40);
        `CHK("resp", RESP_SLVERR, r)
        wstrb <= 4'h0;
        axw(PURGE_OFS, 32'h5A);
        `CHK("bresp", RESP_OKAY, r)
        axr(PURGE_OFS);
        `CHK("purge", PURGE_RST, d[7:0])
        `CHK("card", card, d[15:8])
    endtask : t_trip
    task automatic finish_test();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        tick(20000);
        miscompares++;
        finish_test();
    end
    initial begin
        want = '1;
        want.demand = 1'b0;
        want.provingDemand = 1'b0;
        tick(16);
        resetn <= 1'b1;
        t_power();
        t_hold();
        t_purge();
        t_prove();
        t_trip();
        finish_test();
    end
endmodule : testbench
bind burner_startup_sequencer burner_props #(
    .HOLD_SHOW_CYCLES(HOLD_SHOW_CYCLES), .PURGE_CYC(30 * SEC_CYCLES)
) u_props (.clk(clk), .resetn(resetn), .fieldIn(fieldIn),
    .fieldOut(fieldOut));
